// File: rtl/stp_pkg.sv
// Package of constants for the shared timer prescaler.
`default_nettype none
package stp_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] GTC_OFFSET    = 4'h0;
  localparam logic [3:0] CSEL_OFFSET   = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [7:0] GTC_RESET     = 8'h00;
  localparam int         GTC_PSR_BIT   = 0;
  localparam int         GTC_CAP_BIT   = 6;
  localparam int         GTC_HOLD_BIT  = 7;
  localparam int         CSEL_T1_LSB   = 4;
  localparam logic [2:0] CSEL_RESET    = 3'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // ----------------------------------------------------------------
  // Clock select encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  localparam int         PRE_WIDTH = 10;
  localparam logic [9:0] PRE_MAX   = 10'h3FF;
  localparam logic [9:0] MASK_8    = 10'h007;
  localparam logic [9:0] MASK_64   = 10'h03F;
  localparam logic [9:0] MASK_256  = 10'h0FF;
  localparam logic [9:0] MASK_1024 = 10'h3FF;
endpackage
`default_nettype wire

// File: rtl/stp_top.sv
// Shared prescaler and clock select for two timers, with AXI4-Lite registers.
//
// Behaviour
// - Select 1 gives a count enable every system clock cycle.
// - Four taps divide the system clock by 8, 64, 256 and 1024.
// - Each timer has its own select over one shared prescaler counter.
// - Prescaler runs freely; only prescaler reset changes its state.
// - First prescaled count comes 1 to N cycles after enabling.
// - Prescaler reset restarts the divider for both timers together.
// - External pin is sampled every system clock before edge detection.
// - Synchronizer is a high-transparent latch then rising-edge registers.
// - Select 7 counts rising pin edges, select 6 counts falling edges.
// - Pin edge to count takes 1.5 to 2.5 system cycles.
// - External pin clock never passes through the prescaler.
// - Select 0 gives no count enable; timer stays stopped.
// - Writing one to bit 0 resets prescaler; clears at once unless hold.
// - In hold mode (bit 7) the written reset bit is kept.
// - Writing hold mode to zero clears the prescaler reset bit.
// - Bit 6 routes capture input A (0) or B (1) to second timer.
`default_nettype none
module stp_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Pins
  input  wire logic        external_count_pin,
  input  wire logic        capture_input_a,
  input  wire logic        capture_input_b,
  // Timer side
  output logic             first_timer_count_clock,
  output logic             second_timer_count_clock,
  output logic             second_timer_capture,
  output logic             timers_held
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic       hold_r;
  logic       cap_sel_r;
  logic       psr_r;
  logic [2:0] cs0_r;
  logic [2:0] cs1_r;
  logic [9:0] pre_r;
  logic       aw_got_r;
  logic       w_got_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic       w_lane0_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;
  logic       rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  wire        aw_take  = s_axi_awvalid && !aw_got_r && !bvalid_r;
  wire        w_take   = s_axi_wvalid && !w_got_r && !bvalid_r;
  wire        aw_have  = aw_got_r || aw_take;
  wire        w_have   = w_got_r || w_take;
  wire        wr_fire  = aw_have && w_have && !bvalid_r;
  wire [3:0]  wr_addr  = aw_take ? s_axi_awaddr : aw_addr_r;
  wire [31:0] wr_data  = w_take ? s_axi_wdata : w_data_r;
  wire        wr_lane0 = w_take ? s_axi_wstrb[0] : w_lane0_r;
  wire        wr_gtc   = wr_fire && wr_lane0 && (wr_addr == stp_pkg::GTC_OFFSET);
  wire        wr_csel  = wr_fire && wr_lane0 && (wr_addr == stp_pkg::CSEL_OFFSET);
  wire        wr_known = (wr_addr == stp_pkg::GTC_OFFSET) ||
                         (wr_addr == stp_pkg::CSEL_OFFSET) ||
                         (wr_addr == stp_pkg::STATUS_OFFSET);
  wire [7:0]  csel_wr  = wr_data[7:0];
  wire        hold_new = wr_data[stp_pkg::GTC_HOLD_BIT];
  wire        psr_new  = wr_data[stp_pkg::GTC_PSR_BIT];

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 32'h0000_0000;
      w_lane0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= stp_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r  <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end
      aw_got_r <= aw_have && !wr_fire;
      w_got_r  <= w_have && !wr_fire;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_known ? stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Hold mode written to one keeps the reset bit; written to zero it
  // releases the reset so both timers restart on the same cycle.
  wire hold_nxt = wr_gtc ? hold_new : hold_r;
  wire psr_nxt  = wr_gtc ? (psr_new && hold_new) : (psr_r && hold_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r    <= stp_pkg::GTC_RESET[stp_pkg::GTC_HOLD_BIT];
      cap_sel_r <= stp_pkg::GTC_RESET[stp_pkg::GTC_CAP_BIT];
      psr_r     <= stp_pkg::GTC_RESET[stp_pkg::GTC_PSR_BIT];
      cs0_r     <= stp_pkg::CSEL_RESET;
      cs1_r     <= stp_pkg::CSEL_RESET;
    end else begin
      hold_r <= hold_nxt;
      psr_r  <= psr_nxt;
      if (wr_gtc) begin
        cap_sel_r <= wr_data[stp_pkg::GTC_CAP_BIT];
      end
      if (wr_csel) begin
        cs0_r <= csel_wr[2:0];
        cs1_r <= csel_wr[stp_pkg::CSEL_T1_LSB +: 3];
      end
    end
  end

  // A one-cycle pulse on a plain write plus the kept level in hold mode.
  wire pre_clear = (wr_gtc && psr_new) || psr_r;

  // ----------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= 10'h000;
    end else if (pre_clear) begin
      pre_r <= 10'h000;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // A tap pulses when the low bits of the counter are all ones.
  wire tap8    = (pre_r & stp_pkg::MASK_8) == stp_pkg::MASK_8 && !pre_clear;
  wire tap64   = (pre_r & stp_pkg::MASK_64) == stp_pkg::MASK_64 && !pre_clear;
  wire tap256  = (pre_r & stp_pkg::MASK_256) == stp_pkg::MASK_256 && !pre_clear;
  wire tap1024 = (pre_r & stp_pkg::MASK_1024) == stp_pkg::MASK_1024 && !pre_clear;

  // ----------------------------------------------------------------
  // External pin synchronizer and edge detector
  // ----------------------------------------------------------------
  logic pin_latch;
  logic pin_s1_r;
  logic pin_s2_r;

  always_latch begin
    if (aclk) begin
      pin_latch <= external_count_pin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_latch;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Edges bypass the prescaler entirely.
  wire ext_rise = pin_s1_r && !pin_s2_r;
  wire ext_fall = !pin_s1_r && pin_s2_r;

  // ----------------------------------------------------------------
  // Clock select per timer
  // ----------------------------------------------------------------
  function automatic logic pick(input logic [2:0] cs, input logic t8, input logic t64,
                                input logic t256, input logic t1024, input logic er,
                                input logic ef, input logic held);
    logic p;
    p = 1'b0;
    case (cs)
      stp_pkg::CS_STOP:     p = 1'b0;
      stp_pkg::CS_DIRECT:   p = 1'b1;
      stp_pkg::CS_DIV8:     p = t8;
      stp_pkg::CS_DIV64:    p = t64;
      stp_pkg::CS_DIV256:   p = t256;
      stp_pkg::CS_DIV1024:  p = t1024;
      stp_pkg::CS_EXT_FALL: p = ef;
      stp_pkg::CS_EXT_RISE: p = er;
      default:              p = 1'b0;
    endcase
    return p && !held;
  endfunction

  assign first_timer_count_clock = pick(cs0_r, tap8, tap64, tap256, tap1024,
                                        ext_rise, ext_fall, psr_r);
  assign second_timer_count_clock = pick(cs1_r, tap8, tap64, tap256, tap1024,
                                         ext_rise, ext_fall, psr_r);
  assign second_timer_capture = cap_sel_r ? capture_input_b : capture_input_a;
  assign timers_held = psr_r;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire        rd_take  = s_axi_arvalid && !rvalid_r;
  wire [31:0] gtc_val  = {24'h000000, hold_r, cap_sel_r, 5'h00, psr_r};
  wire [31:0] csel_val = {24'h000000, 1'b0, cs1_r, 1'b0, cs0_r};
  wire [31:0] stat_val = {21'h000000, pin_s2_r, pre_r};
  wire        rd_known = (s_axi_araddr == stp_pkg::GTC_OFFSET) ||
                         (s_axi_araddr == stp_pkg::CSEL_OFFSET) ||
                         (s_axi_araddr == stp_pkg::STATUS_OFFSET);
  wire [31:0] rd_val   = (s_axi_araddr == stp_pkg::GTC_OFFSET)  ? gtc_val  :
                         (s_axi_araddr == stp_pkg::CSEL_OFFSET) ? csel_val :
                         (s_axi_araddr == stp_pkg::STATUS_OFFSET) ? stat_val :
                         32'h0000_0000;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= stp_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_known ? stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_direct_every_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    (cs0_r == stp_pkg::CS_DIRECT && !psr_r) |-> first_timer_count_clock)
    else $error("direct select did not count every cycle");
  chk_direct_second: assert property (@(posedge aclk) disable iff (!aresetn)
    (cs1_r == stp_pkg::CS_DIRECT && !psr_r) |-> second_timer_count_clock)
    else $error("direct select on second timer did not count");
  chk_stop_no_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (cs1_r == stp_pkg::CS_STOP) |-> !second_timer_count_clock)
    else $error("stopped timer received a count");
  chk_div8_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    (tap8 && !pre_clear) |=> !tap8 [*7])
    else $error("divide by 8 tap pulsed too early");
  chk_div8_period: assert property (@(posedge aclk) disable iff (!aresetn)
    (tap8 ##1 !pre_clear [*8]) |-> tap8)
    else $error("divide by 8 tap missing after eight cycles");
  chk_div8_after_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (pre_clear ##1 !pre_clear [*8]) |-> tap8)
    else $error("first divide by 8 tap late after prescaler reset");
  chk_tap_nest_low: assert property (@(posedge aclk) disable iff (!aresetn)
    tap64 |-> tap8)
    else $error("divide by 64 tap not aligned to divide by 8 tap");
  chk_tap_nest_mid: assert property (@(posedge aclk) disable iff (!aresetn)
    tap256 |-> tap64)
    else $error("divide by 256 tap not aligned to divide by 64 tap");
  chk_tap_nest_high: assert property (@(posedge aclk) disable iff (!aresetn)
    tap1024 |-> tap256)
    else $error("divide by 1024 tap not aligned to divide by 256 tap");
  chk_prescaler_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    !pre_clear |=> (pre_r == $past(pre_r) + 10'h001))
    else $error("prescaler did not advance");
  chk_reset_restarts: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_clear |=> (pre_r == 10'h000))
    else $error("prescaler reset did not restart divider");
  chk_pulse_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_gtc && psr_new && !hold_new) |=> (!psr_r && (pre_r == 10'h000)))
    else $error("plain prescaler reset write did not act as a pulse");
  chk_pin_sampled: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (pin_s1_r == $past(external_count_pin)))
    else $error("external pin not sampled every cycle");
  chk_rise_edge_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (cs0_r == stp_pkg::CS_EXT_RISE && !psr_r && pin_s1_r && !pin_s2_r)
      |-> first_timer_count_clock)
    else $error("rising pin edge not counted");
  chk_fall_edge_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (cs1_r == stp_pkg::CS_EXT_FALL && !psr_r && !pin_s1_r && pin_s2_r)
      |-> second_timer_count_clock)
    else $error("falling pin edge not counted");
  chk_ext_no_prescale: assert property (@(posedge aclk) disable iff (!aresetn)
    (cs0_r == stp_pkg::CS_EXT_RISE && first_timer_count_clock)
      |-> (pin_s1_r && !$past(pin_s1_r)))
    else $error("external count not tied to a pin edge");
  chk_psr_self_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (psr_r && !hold_r) |-> 1'b0)
    else $error("prescaler reset bit stuck without hold mode");
  chk_hold_keeps_psr: assert property (@(posedge aclk) disable iff (!aresetn)
    (psr_r && hold_r && !wr_gtc) |=> psr_r)
    else $error("hold mode lost the reset bit");
  chk_hold_latches_psr: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_gtc && psr_new && hold_new) |=> (psr_r && timers_held))
    else $error("hold mode did not keep the written reset bit");
  chk_held_no_count: assert property (@(posedge aclk) disable iff (!aresetn)
    psr_r |-> (!first_timer_count_clock && !second_timer_count_clock))
    else $error("held timer received a count");
  chk_release_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_gtc && !hold_new) |=> !psr_r && !hold_r)
    else $error("release did not clear reset bit");
  chk_capture_route: assert property (@(posedge aclk) disable iff (!aresetn)
    second_timer_capture == (cap_sel_r ? capture_input_b : capture_input_a))
    else $error("capture routed from wrong input");
  chk_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_r && !s_axi_bready) |=> (bvalid_r && $stable(bresp_r)))
    else $error("write response dropped before it was taken");
  chk_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid_r && !s_axi_rready) |=> (rvalid_r && $stable(rdata_r)))
    else $error("read data dropped before it was taken");
endmodule
`default_nettype wire

// File: sim/stp_far_model.sv
// Far-side model: two timer counters and an external count clock source.
`default_nettype none
module stp_far_model #(
  parameter int HALF = 3
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Count enables from the block
  input  wire logic        first_timer_count_clock,
  input  wire logic        second_timer_count_clock,
  // External source
  input  wire logic        ext_run,
  output var  logic        external_count_pin,
  // Timer values
  output var  logic [15:0] cnt0_r,
  output var  logic [15:0] cnt1_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] half_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt0_r <= 16'h0000;
      cnt1_r <= 16'h0000;
    end else begin
      cnt0_r <= cnt0_r + {15'h0000, first_timer_count_clock};
      cnt1_r <= cnt1_r + {15'h0000, second_timer_count_clock};
    end
  end
  // The pin holds each level for HALF cycles, longer than one system clock.
  always_ff @(posedge aclk) begin
    if (!aresetn || !ext_run) begin
      half_cnt_r <= 8'h00;
    end else if (half_cnt_r == 8'(HALF - 1)) begin
      half_cnt_r <= 8'h00;
      external_count_pin <= ~external_count_pin;
    end else begin
      half_cnt_r <= half_cnt_r + 8'h01;
    end
    if (!aresetn) begin
      external_count_pin <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking testbench for the shared timer prescaler.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ext_pin, t0_en, t1_en, cap, held;
  logic        cap_a = 1'b1, cap_b = 1'b0, ext_run = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h00000000, rdata, d;
  logic [1:0]  bresp, rresp;
  logic [15:0] cnt0, cnt1, a0, a1, b0;
  logic [2:0]  s;
  logic [31:0] div [4] = '{32'h00000008, 32'h00000040, 32'h00000100, 32'h00000400};
  int          error_cnt = 0, cmp_count = 0, rises = 0, falls = 0, n;
  always #5 aclk = ~aclk;
  always @(posedge ext_pin) rises++;
  always @(negedge ext_pin) falls++;
  stp_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .external_count_pin(ext_pin), .capture_input_a(cap_a), .capture_input_b(cap_b),
    .first_timer_count_clock(t0_en), .second_timer_count_clock(t1_en),
    .second_timer_capture(cap), .timers_held(held));
  stp_far_model #(.HALF(3)) u_model (.aclk(aclk), .aresetn(aresetn),
    .first_timer_count_clock(t0_en), .second_timer_count_clock(t1_en), .ext_run(ext_run),
    .external_count_pin(ext_pin), .cnt0_r(cnt0), .cnt1_r(cnt1));
  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("write response", {30'h00000000, bresp}, {30'h00000000, er});
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk(nm, d, e);
    chk("read response", {30'h00000000, rresp}, {30'h00000000, er});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
    a0 = cnt0;
    a1 = cnt1;
  endtask
  function automatic logic [31:0] sel(input logic [2:0] s0, input logic [2:0] s1);
    return {25'h0000000, s1, 1'b0, s0};
  endfunction
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd("control reset", stp_pkg::GTC_OFFSET, 32'h00000000, stp_pkg::RESP_OKAY);
    rd("select reset", stp_pkg::CSEL_OFFSET, 32'h00000000, stp_pkg::RESP_OKAY);
    rd("unmapped read", 4'hC, 32'h00000000, stp_pkg::RESP_SLVERR);
    wr(4'hC, 32'h000000FF, stp_pkg::RESP_SLVERR);
    cyc(100);
    chk("stopped counts", cnt0 | cnt1, 32'h00000000);
    $display("test reset done");
    wr(stp_pkg::CSEL_OFFSET, sel(stp_pkg::CS_DIRECT, stp_pkg::CS_DIRECT), stp_pkg::RESP_OKAY);
    cyc(2);
    b0 = cnt0;
    n = cnt1;
    cyc(200);
    chk("direct count", cnt0 - b0, 32'h000000C8);
    chk("direct count t1", cnt1 - 16'(n), 32'h000000C8);
    for (int i = 0; i < 4; i++) begin
      s = stp_pkg::CS_DIV8 + 3'(i);
      wr(stp_pkg::CSEL_OFFSET, sel(s, 3'h7 - s), stp_pkg::RESP_OKAY);
      cyc(2);
      b0 = cnt0;
      n = cnt1;
      cyc(2048);
      chk("tap count t0", cnt0 - b0, 32'h00000800 / div[i]);
      chk("tap count t1", cnt1 - 16'(n), 32'h00000800 / div[3 - i]);
    end
    $display("test taps done");
    wr(stp_pkg::CSEL_OFFSET, sel(stp_pkg::CS_DIV8, stp_pkg::CS_DIV64), stp_pkg::RESP_OKAY);
    wr(stp_pkg::GTC_OFFSET, 32'h00000081, stp_pkg::RESP_OKAY);
    rd("held control", stp_pkg::GTC_OFFSET, 32'h00000081, stp_pkg::RESP_OKAY);
    chk("held flag", {31'h00000000, held}, 32'h00000001);
    cyc(0);
    repeat (100) @(posedge aclk);
    chk("halted", (cnt0 - a0) + (cnt1 - a1), 32'h00000000);
    wr(stp_pkg::GTC_OFFSET, 32'h00000000, stp_pkg::RESP_OKAY);
    while (cnt1 == a1) @(posedge aclk);
    chk("aligned restart", cnt0 - a0, 32'h00000008);
    rd("released control", stp_pkg::GTC_OFFSET, 32'h00000000, stp_pkg::RESP_OKAY);
    chk("held flag off", {31'h00000000, held}, 32'h00000000);
    wr(stp_pkg::GTC_OFFSET, 32'h00000001, stp_pkg::RESP_OKAY);
    rd("pulse bit", stp_pkg::GTC_OFFSET, 32'h00000000, stp_pkg::RESP_OKAY);
    // The restart lands five cycles before the status read samples the prescaler.
    rd("status", stp_pkg::STATUS_OFFSET, 32'h00000005, stp_pkg::RESP_OKAY);
    chk("prescaler restarted", {31'h00000000, d[9:0] < 10'h010}, 32'h00000001);
    $display("test hold done");
    for (int i = 0; i < 4; i++) begin
      cap_a <= i[0];
      cap_b <= ~i[0];
      wr(stp_pkg::GTC_OFFSET, {25'h0000000, i[1], 6'h00}, stp_pkg::RESP_OKAY);
      @(posedge aclk);
      chk("capture route", {31'h00000000, cap}, {31'h00000000, i[1] ? cap_b : cap_a});
    end
    $display("test capture done");
    // Pin is low and steady while the external selects are set.
    wr(stp_pkg::CSEL_OFFSET, sel(stp_pkg::CS_EXT_RISE, stp_pkg::CS_EXT_FALL), stp_pkg::RESP_OKAY);
    cyc(4);
    rises = 0;
    falls = 0;
    ext_run <= 1'b1;
    @(posedge ext_pin);
    #1;
    b0 = cnt0;
    n = 0;
    while (cnt0 == b0 && n < 8) begin
      @(posedge aclk);
      #1;
      n++;
    end
    chk("pin latency", {31'h00000000, n >= 2 && n <= 4}, 32'h00000001);
    repeat (60) @(posedge aclk);
    ext_run <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("rise count", cnt0 - a0, rises);
    chk("fall count", cnt1 - a1, falls);
    $display("test external done");
    close_out();
  end
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
